// >>> src/fpes_pkg.sv
// package for the flash program/erase host controller
// assumes one 125 MHz clock; flash bus timing is built from cycle counts
package fpes_pkg;
  // ---------------------------------------------------------------
  // flash commands
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  // ---------------------------------------------------------------
  // operation_status bit positions
  // ---------------------------------------------------------------
  localparam int SR_READY = 7;
  localparam int SR_PAUSED = 6;
  localparam int SR_ERASE_FAIL = 5;
  localparam int SR_PROG_FAIL = 4;
  localparam int SR_SUPPLY_LOW = 3;
  localparam logic [7:0] SR_VALID_MASK = 8'hF8;
  // ---------------------------------------------------------------
  // wishbone register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;
  // control register op codes (bits 2:0), bit 3 = boot unlock
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_ERASE = 3'h2;
  localparam logic [2:0] OP_SUSPEND = 3'h3;
  localparam logic [2:0] OP_RESUME = 3'h4;
  localparam logic [2:0] OP_READ = 3'h5;
  localparam logic [2:0] OP_CLEAR = 3'h6;
  localparam int CTRL_UNLOCK = 3;
  // ---------------------------------------------------------------
  // bus timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int T_STROBE_NS = 150;
  localparam int T_RECOVER_NS = 480;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  typedef enum logic [3:0] {
    FPES_IDLE, FPES_WR_LOW, FPES_WR_HIGH, FPES_RD_LOW, FPES_RD_HIGH, FPES_NEXT
  } fpes_state_t;
endpackage

// >>> src/fpes_host.sv
// host controller that drives a byte-wide boot-block flash through its pins
// assumes a classic wishbone master; the flash pins are asynchronous to i_clk
`timescale 1ns/100ps
// Overview of operation
// - after pause, read array command; software picks a block outside erase
// - program is setup command then address and data write
// - reserved status bits 2..0 are masked on every poll
// - failure flags are judged only after ready reads one
// - supply low blocks new program and erase ops until a clear op
// - erase writes setup then confirm, both at the block address
// - unlock level is raised before confirm, held until ready
// - chip select returns high before every status read
module fpes_host
  import fpes_pkg::*;
#(
  parameter int ADDR_W = 17
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic [ADDR_W-1:0] o_fl_addr,
  output logic [7:0] o_fl_dq,
  output logic o_fl_dq_oe,
  input wire logic [7:0] i_fl_dq,
  output logic o_fl_ce_n,
  output logic o_fl_oe_n,
  output logic o_fl_we_n,
  output logic o_fl_pd_n,
  output logic o_fl_unlock_high
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  fpes_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] data_reg;
  logic [2:0] op_reg;
  logic unlock_reg;
  logic busy_reg;
  logic [1:0] step_reg;
  logic [7:0] status_reg;
  logic [7:0] rd_data_reg;
  logic refused_reg;
  logic susp_pend_reg;
  logic [7:0] dq_meta_reg;
  logic [7:0] dq_sync_reg;
  logic [7:0] wr_byte;
  logic last_write;
  logic wb_req;

  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;

  // two-stage synchroniser on the data pins
  always_ff @(posedge i_clk) begin
    dq_meta_reg <= i_fl_dq;
    dq_sync_reg <= dq_meta_reg;
  end

  // ---------------------------------------------------------------
  // byte to drive for the current step of the op
  // ---------------------------------------------------------------
  always_comb begin
    wr_byte = CMD_READ_STATUS;
    last_write = 1'b1;
    case (op_reg)
      OP_PROGRAM: begin
        wr_byte = (step_reg == 2'd0) ? CMD_PROG_SETUP : data_reg;
        last_write = (step_reg != 2'd0);
      end
      OP_ERASE: begin
        wr_byte = (step_reg == 2'd0) ? CMD_ERASE_SETUP : CMD_CONFIRM;
        last_write = (step_reg != 2'd0);
      end
      OP_SUSPEND: wr_byte = CMD_SUSPEND;
      OP_RESUME: wr_byte = CMD_CONFIRM;
      OP_READ: wr_byte = CMD_READ_ARRAY;
      OP_CLEAR: wr_byte = CMD_CLEAR_STATUS;
      default: wr_byte = CMD_READ_STATUS;
    endcase
  end

  // ---------------------------------------------------------------
  // wishbone slave: one-cycle ack, registers below
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we) begin
        case (i_wb_adr)
          REG_CTRL: o_wb_dat <= {28'h0, unlock_reg, op_reg};
          REG_ADDR: o_wb_dat <= {{(32-ADDR_W){1'b0}}, addr_reg};
          REG_DATA: o_wb_dat <= {24'h0, rd_data_reg};
          REG_STAT: o_wb_dat <= {22'h0, refused_reg, busy_reg, status_reg};
          default: o_wb_dat <= 32'h0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // command port and pin sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= FPES_IDLE;
      cnt_reg <= '0;
      addr_reg <= '0;
      data_reg <= 8'h00;
      op_reg <= OP_NONE;
      unlock_reg <= 1'b0;
      busy_reg <= 1'b0;
      step_reg <= 2'd0;
      status_reg <= 8'h00;
      rd_data_reg <= 8'h00;
      refused_reg <= 1'b0;
      susp_pend_reg <= 1'b0;
      o_fl_addr <= '0;
      o_fl_dq <= 8'h00;
      o_fl_dq_oe <= 1'b0;
      o_fl_ce_n <= 1'b1;
      o_fl_oe_n <= 1'b1;
      o_fl_we_n <= 1'b1;
      o_fl_pd_n <= 1'b1;
      o_fl_unlock_high <= 1'b0;
    end else begin
      if (wb_req && i_wb_we && !busy_reg) begin
        if (i_wb_adr == REG_ADDR) begin
          addr_reg <= i_wb_dat[ADDR_W-1:0];
        end
        if (i_wb_adr == REG_DATA && i_wb_sel[0]) begin
          data_reg <= i_wb_dat[7:0];
        end
        if (i_wb_adr == REG_CTRL && i_wb_sel[0]) begin
          // new program or erase refused while supply low is set
          if ((i_wb_dat[2:0] == OP_PROGRAM || i_wb_dat[2:0] == OP_ERASE)
              && status_reg[SR_SUPPLY_LOW]) begin
            refused_reg <= 1'b1;
          end else begin
            refused_reg <= 1'b0;
            op_reg <= i_wb_dat[2:0];
            unlock_reg <= i_wb_dat[CTRL_UNLOCK];
            busy_reg <= 1'b1;
            step_reg <= 2'd0;
            cnt_reg <= '0;
            state_reg <= FPES_WR_LOW;
            // unlock level raised before the confirm write
            o_fl_unlock_high <= i_wb_dat[CTRL_UNLOCK];
          end
        end
      end
      // suspend during erase
      // an erase keeps the port busy, so the suspend waits for the next gap between polls
      if (wb_req && i_wb_we && busy_reg && i_wb_adr == REG_CTRL && i_wb_sel[0]
          && i_wb_dat[2:0] == OP_SUSPEND && op_reg == OP_ERASE) begin
        susp_pend_reg <= 1'b1;
      end
      case (state_reg)
        FPES_IDLE: begin
          o_fl_dq_oe <= 1'b0;
        end
        FPES_WR_LOW: begin
          o_fl_addr <= addr_reg;
          o_fl_dq <= wr_byte;
          o_fl_dq_oe <= 1'b1;
          o_fl_ce_n <= 1'b0;
          o_fl_we_n <= 1'b0;
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(STROBE_CYC)) begin
            cnt_reg <= '0;
            state_reg <= FPES_WR_HIGH;
          end
        end
        FPES_WR_HIGH: begin
          // data held stable across the rising strobe edge
          o_fl_we_n <= 1'b1;
          o_fl_ce_n <= 1'b1;
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(RECOVER_CYC)) begin
            cnt_reg <= '0;
            o_fl_dq_oe <= 1'b0;
            step_reg <= step_reg + 2'd1;
            state_reg <= last_write ? FPES_NEXT : FPES_WR_LOW;
          end
        end
        FPES_NEXT: begin
          // after a program or erase, only status polls
          if (op_reg == OP_READ || op_reg == OP_CLEAR) begin
            state_reg <= (op_reg == OP_READ) ? FPES_RD_LOW : FPES_IDLE;
            busy_reg <= (op_reg == OP_READ);
            // drop local flags
            // the clear op does no poll; a stale supply-low copy would refuse the retry
            if (op_reg == OP_CLEAR) begin
              status_reg[SR_ERASE_FAIL] <= 1'b0;
              status_reg[SR_PROG_FAIL] <= 1'b0;
              status_reg[SR_SUPPLY_LOW] <= 1'b0;
            end
          end else begin
            state_reg <= FPES_RD_LOW;
          end
        end
        FPES_RD_LOW: begin
          o_fl_addr <= addr_reg;
          o_fl_ce_n <= 1'b0;
          o_fl_oe_n <= 1'b0;
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(STROBE_CYC)) begin
            cnt_reg <= '0;
            state_reg <= FPES_RD_HIGH;
            if (op_reg == OP_READ) begin
              rd_data_reg <= dq_sync_reg;
            end else begin
              status_reg <= dq_sync_reg & SR_VALID_MASK;
            end
          end
        end
        FPES_RD_HIGH: begin
          // strobes back high before the next poll
          o_fl_ce_n <= 1'b1;
          o_fl_oe_n <= 1'b1;
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(RECOVER_CYC)) begin
            cnt_reg <= '0;
            state_reg <= FPES_RD_LOW;
            // done after one read for the read op, otherwise when ready, or for suspend when also paused
            if (op_reg == OP_READ || (status_reg[SR_READY] &&
                (op_reg != OP_SUSPEND || status_reg[SR_PAUSED]))) begin
              busy_reg <= 1'b0;
              state_reg <= FPES_IDLE;
              susp_pend_reg <= 1'b0;
              // unlock level held until ready reads one
              o_fl_unlock_high <= 1'b0;
            end else if (susp_pend_reg) begin
              susp_pend_reg <= 1'b0;
              op_reg <= OP_SUSPEND;
              step_reg <= 2'd0;
              state_reg <= FPES_WR_LOW;
            end
          end
        end
        default: state_reg <= FPES_IDLE;
      endcase
    end
  end
endmodule

// >>> testbench/fpes_host_chk.sv
// pin and wishbone checker for the flash host controller
// bound into fpes_host; sees its ports only
`timescale 1ns/100ps
module fpes_host_chk (
  input wire logic i_clk, i_rst, i_wb_cyc, i_wb_stb, o_wb_ack,
  input wire logic o_fl_ce_n, o_fl_oe_n, o_fl_we_n, o_fl_dq_oe, o_fl_pd_n, o_fl_unlock_high
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_ACK_NEXT: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  AST_WR_DRIVE: assert property (!o_fl_we_n |-> o_fl_dq_oe && !o_fl_ce_n && o_fl_oe_n)
    else $error("write strobe without driven bus");
  AST_WR_WIDTH: assert property ($fell(o_fl_we_n) |-> !o_fl_we_n [*8])
    else $error("write strobe too short");
  AST_RD_FREE: assert property (!o_fl_oe_n |-> !o_fl_dq_oe && o_fl_we_n && !o_fl_ce_n)
    else $error("read with bus driven or write low");
  AST_RD_TOGGLE: assert property ($rose(o_fl_oe_n) |-> o_fl_ce_n [*8])
    else $error("chip select not returned high between reads");
  AST_PD_HELD: assert property (o_fl_pd_n)
    else $error("power-down pin dropped");
  AST_UNLOCK_DROP: assert property ($fell(o_fl_unlock_high) |-> o_fl_we_n && o_fl_oe_n)
    else $error("unlock level dropped inside a bus cycle");
  AST_RST_IDLE: assert property (disable iff (1'b0) i_rst |=>
    o_fl_ce_n && o_fl_we_n && o_fl_oe_n && !o_wb_ack) else $error("pins not idle after reset");
endmodule
bind fpes_host fpes_host_chk chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_fl_ce_n(o_fl_ce_n), .o_fl_oe_n(o_fl_oe_n),
  .o_fl_we_n(o_fl_we_n), .o_fl_dq_oe(o_fl_dq_oe), .o_fl_pd_n(o_fl_pd_n),
  .o_fl_unlock_high(o_fl_unlock_high));

// >>> testbench/fpes_flash_model.sv
// behavioural boot-block flash facing the host controller
// busy times are shortened so the run stays short
`timescale 1ns/100ps
module fpes_flash_model #(parameter int STEP_NS = 2000, parameter int ER_STEPS = 8) (
  input wire logic [16:0] i_addr,
  input wire logic [7:0] i_dq,
  input wire logic i_ce_n, i_oe_n, i_we_n, i_pd_n, i_unlock_high, i_supply_ok,
  output logic [7:0] o_dq = 8'h5A
);
  logic [7:0] mem [int];
  logic [7:0] sr = 8'h80;
  logic stat_mode = 1'b0;
  logic susp_req = 1'b0;
  int pend = 0;
  function automatic int blk(int a);
    return a >= 'h1E000 ? 9 : a >= 'h1C000 ? a / 'h1000 : 0;
  endfunction
  always @(i_ce_n, i_oe_n)
    if (!i_ce_n && !i_oe_n) o_dq = stat_mode ? sr : (mem.exists(i_addr) ? mem[i_addr] : 8'hFF);
    else o_dq = ~o_dq;
  task automatic run(bit er, int a, logic [7:0] d);
    bit ab;
    pend = 0;
    ab = 1'b0;
    if (sr[3]) return;
    if (!i_supply_ok || (blk(a) == 9 && !i_unlock_high)) begin
      sr[er ? 5 : 4] = 1'b1;
      sr[3] = !i_supply_ok;
      return;
    end
    sr[7] = 1'b0;
    pend = er ? 3 : 0;
    fork begin
      for (int i = 0; i < (er ? ER_STEPS : 1) && !ab; i++) begin
        #(STEP_NS);
        if (susp_req) begin sr[7:6] = 2'b11; wait (!sr[6]); end
        ab = !i_pd_n || !i_supply_ok;
      end
      sr[3] = !i_supply_ok;
      if (ab) sr[er ? 5 : 4] = 1'b1;
      else if (er) foreach (mem[k]) begin if (blk(k) == blk(a)) mem[k] = 8'hFF; end
      else mem[a] = (mem.exists(a) ? mem[a] : 8'hFF) & d;
      sr[7] = 1'b1;
      pend = 0;
    end join_none
  endtask
  // capture when the first strobe rises; both strobes may rise in one step
  wire logic wr_act = !i_we_n && !i_ce_n;
  always @(negedge wr_act) begin
    if (!sr[7]) begin
      if (i_dq == 8'hB0 && pend == 3) susp_req = 1'b1;
      stat_mode = 1'b1;
    end else if (pend == 1 || pend == 2) begin
      stat_mode = 1'b1;
      if (pend == 2 && i_dq != 8'hD0) begin sr[5:4] = 2'b11; pend = 0; end
      else run(pend == 2, i_addr, i_dq);
    end else case (i_dq)
      8'hFF: stat_mode = 1'b0;
      8'h70: stat_mode = 1'b1;
      8'h50: sr[5:3] = 3'b000;
      8'h40: pend = 1;
      8'h20: pend = 2;
      8'hD0: if (sr[6]) begin sr[7:6] = 2'b00; susp_req = 1'b0; stat_mode = 1'b1; end
      default: ;
    endcase
  end
endmodule

// >>> testbench/fpes_host_tb_top.sv
// self-checking bench: wishbone master, reference values, flash model
// runs the host controller against the behavioural flash at 125 MHz
`timescale 1ns/100ps
module fpes_host_tb_top;
  import fpes_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, supply_ok = 1'b1;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, st;
  logic ack, ce_n, oe_n, we_n, pd_n, unl, dq_oe;
  logic [16:0] fa;
  logic [7:0] hdq, mdq;
  wire logic [7:0] bus = dq_oe ? hdq : mdq;
  int failures = 0, comparisons = 0;
  int ref_mem [int];
  always #4 i_clk = ~i_clk;
  fpes_host dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hF), .o_wb_dat(rdat), .o_wb_ack(ack),
    .o_fl_addr(fa), .o_fl_dq(hdq), .o_fl_dq_oe(dq_oe), .i_fl_dq(bus), .o_fl_ce_n(ce_n),
    .o_fl_oe_n(oe_n), .o_fl_we_n(we_n), .o_fl_pd_n(pd_n), .o_fl_unlock_high(unl));
  fpes_flash_model flash_u (.i_addr(fa), .i_dq(bus), .i_ce_n(ce_n), .i_oe_n(oe_n),
    .i_we_n(we_n), .i_pd_n(pd_n), .i_unlock_high(unl), .i_supply_ok(supply_ok), .o_dq(mdq));
  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wb(logic w, logic [3:0] a, logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin failures++; end_sim(); end
  endtask
  // one controller operation, then poll until it is no longer busy
  task automatic op(logic [3:0] c, int a, int d, output logic [31:0] s);
    int n;
    n = 0;
    wb(1'b1, REG_ADDR, a, s);
    wb(1'b1, REG_DATA, d, s);
    wb(1'b1, REG_CTRL, c, s);
    do begin
      wb(1'b0, REG_STAT, 32'h0, s);
      n++;
    end while (s[8] !== 1'b0 && n < 3000);
    if (n >= 3000) begin failures++; end_sim(); end
  endtask
  task automatic rd_chk(int a);
    logic [31:0] q;
    op({1'b0, OP_READ}, a, 0, q);
    wb(1'b0, REG_DATA, 32'h0, q);
    chk("array byte", q[7:0], ref_mem.exists(a) ? ref_mem[a] : 'hFF);
  endtask
  initial begin
    int a, d;
    void'($urandom(45283));
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    wb(1'b0, 4'h1, 32'h0, st);
    chk("unmapped", st, 32'h0);
    op({1'b0, OP_NONE}, 0, 0, st);
    chk("idle status", st, 32'h80);
    // repeated address checks that only ones turned to zero matter
    for (int i = 0; i < 4; i++) begin
      a = (i < 2) ? 'h100 : $urandom_range('h1BFFF);
      d = $urandom_range(255);
      op({1'b0, OP_PROGRAM}, a, d, st);
      ref_mem[a] = (ref_mem.exists(a) ? ref_mem[a] : 'hFF) & d;
      chk("program status", st, 32'h80);
      rd_chk(a);
    end
    op({1'b0, OP_PROGRAM}, 'h1E010, 'h00, st);
    chk("boot locked", st, 32'h90);
    op({1'b0, OP_CLEAR}, 0, 0, st);
    op({1'b0, OP_NONE}, 0, 0, st);
    chk("cleared", st, 32'h80);
    op({1'b1, OP_PROGRAM}, 'h1E010, 'h3C, st);
    ref_mem['h1E010] = 'h3C;
    chk("boot unlocked", st, 32'h80);
    rd_chk('h1E010);
    op({1'b0, OP_ERASE}, 'h100, 0, st);
    chk("erase status", st, 32'h80);
    foreach (ref_mem[k]) if (k < 'h1C000) ref_mem[k] = 'hFF;
    rd_chk('h100);
    rd_chk('h1E010);
    // a parameter block erase is paused, another block is read, then the erase resumes
    wb(1'b1, REG_ADDR, 'h1D000, st);
    wb(1'b1, REG_CTRL, {1'b0, OP_ERASE}, st);
    repeat (400) @(posedge i_clk);
    op({1'b0, OP_SUSPEND}, 'h1D000, 0, st);
    chk("suspended", st, 32'hC0);
    rd_chk('h1E010);
    op({1'b0, OP_RESUME}, 'h1D000, 0, st);
    chk("resumed", st, 32'h80);
    // supply falls in mid-erase, then a new attempt must be refused
    wb(1'b1, REG_ADDR, 'h1C000, st);
    wb(1'b1, REG_CTRL, {1'b0, OP_ERASE}, st);
    repeat (600) @(posedge i_clk);
    supply_ok <= 1'b0;
    op({1'b0, OP_NONE}, 0, 0, st);
    chk("abort status", st, 32'hA8);
    op({1'b0, OP_PROGRAM}, 'h200, 'h00, st);
    chk("refused", st, 32'h2A8);
    supply_ok <= 1'b1;
    op({1'b0, OP_CLEAR}, 0, 0, st);
    chk("clear op", st, 32'h80);
    op({1'b0, OP_NONE}, 0, 0, st);
    chk("recovered", st[7:0], 8'h80);
    end_sim();
  end
endmodule
